// ===== design/reset_watchdog_clock_monitor.sv
// reset sequencer, software watchdog and clock monitor with wishbone slave
//
// Implementation choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "rst_wdog_defines.svh"

module reset_watchdog_clock_monitor #(
	parameter int POR_CYCLES = `POR_CYCLES,
	parameter int MON_CYCLES = `MON_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic reset_pin_i,
	output logic reset_pin_o,
	output logic reset_pin_oe_o,
	input wire logic e_clk_en_i,
	input wire logic stop_i,
	input wire logic special_mode_i,
	input wire logic watchdog_disable_cfg_i,
	output logic cpu_reset_o,
	output logic [15:0] reset_vector_o,
	output logic irq_edge_select_o,
	output logic converter_power_up_o,
	output logic converter_clock_sel_o,
	output logic osc_start_delay_en_o
);

	// ==========================================
	// pin synchroniser
	logic [2:0] pin_sync_r;
	logic pin_level_r;
	wire pin_agree = pin_sync_r[1] == pin_sync_r[2];

	always_ff @(posedge clk_i) begin
		pin_sync_r <= {pin_sync_r[1:0], reset_pin_i};
		if (rst_i)
			pin_level_r <= 1'b0;
		else if (pin_agree)
			pin_level_r <= pin_sync_r[2];
	end

	// ==========================================
	// bus decode
	rst_wdog_pkg::wb_req_t req;
	assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, adr: adr_i,
		sel: sel_i, dat: dat_i};
	wire bus_take = req.cyc & req.stb & ~ack_o;
	// writes land on the edge at which the master sees ack high
	wire bus_done = req.cyc & req.stb & ack_o;
	wire wr_lane0 = bus_done & req.we & req.sel[0];
	wire hit_opt = req.adr == `ADDR_OPTIONS;
	wire hit_svc = req.adr == `ADDR_SERVICE;
	wire hit_test = req.adr == `ADDR_TEST;
	wire hit_stat = req.adr == `ADDR_STATUS;
	wire wr_opt = wr_lane0 & hit_opt;
	wire wr_svc = wr_lane0 & hit_svc;
	wire wr_test = wr_lane0 & hit_test;
	wire [7:0] wdat = req.dat[7:0];

	// ==========================================
	// sequencer state
	rst_wdog_pkg::seq_state_t state_r, state_nxt;
	rst_wdog_pkg::cause_t cause_r;
	logic [11:0] cnt_r;
	logic special_r;
	logic wdog_en_r;
	logic in_reset;
	logic wdog_fire, mon_fire;

	// ==========================================
	// options register
	logic [7:0] options_r;
	logic rate_locked_r;
	logic [6:0] win_cnt_r;
	logic test_inhibit_r;
	wire rate_open = special_r |
		(~rate_locked_r & (win_cnt_r < 7'(`RATE_WINDOW)));

	always_ff @(posedge clk_i) begin
		if (rst_i | in_reset) begin
			options_r <= `OPT_RESET;
			rate_locked_r <= 1'b0;
			win_cnt_r <= 7'h00;
			test_inhibit_r <= 1'b1;
		end else begin
			if (e_clk_en_i && win_cnt_r < 7'(`RATE_WINDOW))
				win_cnt_r <= win_cnt_r + 7'h01;
			if (wr_opt) begin
				options_r[7:3] <= wdat[7:3];
				if (rate_open) begin
					options_r[1:0] <= wdat[1:0];
					rate_locked_r <= 1'b1;
				end
			end
			if (wr_test)
				test_inhibit_r <= wdat[0];
		end
	end

	// ==========================================
	// watchdog: prescaler, rate divider, arm
	logic [20:0] wdog_cnt_r;
	logic armed_r;
	logic [20:0] wdog_limit;
	always_comb begin
		case (options_r[1:0])
			2'b00: wdog_limit = 21'h007FFF;
			2'b01: wdog_limit = 21'h01FFFF;
			2'b10: wdog_limit = 21'h07FFFF;
			default: wdog_limit = 21'h1FFFFF;
		endcase
	end
	wire svc_clear = wr_svc & (wdat == `SVC_CLEAR) & armed_r;
	wire wdog_allowed = wdog_en_r & ~(special_r & test_inhibit_r);

	always_ff @(posedge clk_i) begin
		if (rst_i | in_reset) begin
			wdog_cnt_r <= 21'h000000;
			armed_r <= 1'b0;
		end else begin
			if (wr_svc && wdat == `SVC_ARM)
				armed_r <= 1'b1;
			else if (svc_clear)
				armed_r <= 1'b0;
			if (svc_clear)
				wdog_cnt_r <= 21'h000000;
			else if (e_clk_en_i && !stop_i)
				wdog_cnt_r <= wdog_cnt_r + 21'h000001;
		end
	end
	assign wdog_fire = ~in_reset & wdog_allowed & e_clk_en_i & ~stop_i &
		(wdog_cnt_r == wdog_limit);

	// ==========================================
	// clock monitor: counts gap between E edges
	logic [15:0] mon_cnt_r;
	always_ff @(posedge clk_i) begin
		if (rst_i | in_reset | e_clk_en_i)
			mon_cnt_r <= 16'h0000;
		else if (mon_cnt_r != 16'hFFFF)
			mon_cnt_r <= mon_cnt_r + 16'h0001;
	end
	assign mon_fire = ~in_reset & options_r[`OPT_MON_EN] &
		(mon_cnt_r >= 16'(MON_CYCLES));

	// ==========================================
	// reset sequencer
	assign in_reset = state_r != rst_wdog_pkg::ST_RUN;
	wire cnt_done = cnt_r == 12'h000;

	// settle also waits out the pin synchroniser latency
	logic [2:0] settle_cyc_r;
	wire settle_ok = settle_cyc_r >= 3'(`PIN_SYNC_CYCLES);

	always_ff @(posedge clk_i) begin
		if (rst_i || state_r != rst_wdog_pkg::ST_SETTLE)
			settle_cyc_r <= 3'h0;
		else if (!settle_ok)
			settle_cyc_r <= settle_cyc_r + 3'h1;
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			rst_wdog_pkg::ST_POR:
				if (cnt_done)
					state_nxt = rst_wdog_pkg::ST_WAIT_PIN;
			rst_wdog_pkg::ST_DRIVE:
				if (cnt_done && e_clk_en_i)
					state_nxt = rst_wdog_pkg::ST_SETTLE;
			rst_wdog_pkg::ST_SETTLE:
				if (cnt_done && settle_ok)
					state_nxt = rst_wdog_pkg::ST_WAIT_PIN;
			rst_wdog_pkg::ST_WAIT_PIN:
				if (pin_level_r)
					state_nxt = rst_wdog_pkg::ST_RUN;
			rst_wdog_pkg::ST_RUN:
				if (!pin_level_r || wdog_fire || mon_fire)
					state_nxt = rst_wdog_pkg::ST_DRIVE;
			default:
				state_nxt = rst_wdog_pkg::ST_POR;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= rst_wdog_pkg::ST_POR;
			cnt_r <= 12'(POR_CYCLES - 1);
			cause_r <= rst_wdog_pkg::CAUSE_EXTERNAL;
			special_r <= 1'b0;
			wdog_en_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (state_r == rst_wdog_pkg::ST_RUN &&
					state_nxt == rst_wdog_pkg::ST_DRIVE) begin
				cnt_r <= 12'(`PIN_DRIVE_CYCLES - 1);
				if (mon_fire)
					cause_r <= rst_wdog_pkg::CAUSE_MONITOR;
				else
					cause_r <= rst_wdog_pkg::CAUSE_WATCHDOG;
			end else if (state_r == rst_wdog_pkg::ST_DRIVE &&
					state_nxt == rst_wdog_pkg::ST_SETTLE)
				cnt_r <= 12'(`PIN_SAMPLE_CYCLES - 1);
			else if (state_r == rst_wdog_pkg::ST_POR && !cnt_done)
				cnt_r <= cnt_r - 12'h001;
			else if (state_r != rst_wdog_pkg::ST_POR && e_clk_en_i &&
					!cnt_done)
				cnt_r <= cnt_r - 12'h001;
			if (state_r == rst_wdog_pkg::ST_SETTLE &&
					state_nxt == rst_wdog_pkg::ST_WAIT_PIN &&
					!pin_level_r)
				cause_r <= rst_wdog_pkg::CAUSE_EXTERNAL;
			if (state_r == rst_wdog_pkg::ST_POR)
				cause_r <= rst_wdog_pkg::CAUSE_EXTERNAL;
			if (in_reset) begin
				special_r <= special_mode_i;
				wdog_en_r <= ~watchdog_disable_cfg_i;
			end
		end
	end

	// ==========================================
	// outputs and vector select
	logic [15:0] vec_sel;
	always_comb begin
		case (cause_r)
			rst_wdog_pkg::CAUSE_MONITOR: vec_sel = `VEC_MONITOR;
			rst_wdog_pkg::CAUSE_WATCHDOG: vec_sel = `VEC_WATCHDOG;
			default: vec_sel = `VEC_NORMAL;
		endcase
		if (special_r)
			vec_sel = vec_sel & `VEC_SPECIAL_MASK;
	end

	logic [31:0] rdata;
	always_comb begin
		rdata = 32'h00000000;
		if (hit_opt)
			rdata = {24'h000000, options_r[7:3], 1'b0, options_r[1:0]};
		else if (hit_test)
			rdata = {31'h00000000, test_inhibit_r};
		else if (hit_stat)
			rdata = {27'h0000000, armed_r, wdog_allowed, special_r,
				cause_r};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
			reset_pin_o <= 1'b0;
			reset_pin_oe_o <= 1'b0;
			cpu_reset_o <= 1'b1;
			reset_vector_o <= `VEC_NORMAL;
			irq_edge_select_o <= 1'b0;
			converter_power_up_o <= 1'b0;
			converter_clock_sel_o <= 1'b0;
			osc_start_delay_en_o <= 1'b1;
		end else begin
			ack_o <= bus_take;
			dat_o <= (bus_take & ~req.we) ? rdata : 32'h00000000;
			reset_pin_o <= 1'b0;
			reset_pin_oe_o <= ~(state_nxt == rst_wdog_pkg::ST_DRIVE ||
				state_nxt == rst_wdog_pkg::ST_POR);
			cpu_reset_o <= state_nxt != rst_wdog_pkg::ST_RUN;
			reset_vector_o <= vec_sel;
			irq_edge_select_o <= options_r[`OPT_IRQ_EDGE_SELECT];
			converter_power_up_o <= options_r[`OPT_CONVERTER_POWER_UP];
			converter_clock_sel_o <= options_r[`OPT_CONVERTER_CLOCK_SEL];
			osc_start_delay_en_o <= options_r[`OPT_DLY];
		end
	end

endmodule : reset_watchdog_clock_monitor

// ===== design/rst_wdog_defines.svh
// offsets, field positions, reset values and timing counts for the reset block
// Contract
// - four reset sources, two dedicated vectors
// - reset aborts, initialises, loads start vector
// - hold reset 4064 cycles after power-up
// - stay in reset while pin low
// - drive reset pin low four E cycles
// - sample pin two cycles after release
// - watchdog enable latched only at reset
// - disable bit 1 blocks watchdog reset
// - test inhibit bit blocks watchdog resets (code: only while special mode is latched)
// - period E/2^15 times 1,4,16,64
// - rate field once in 64 cycles (code: any time while special mode is latched)
// - service by 0x55 then 0xAA
// - watchdog timeout starts watchdog reset
// - missing clock edges cause reset
// - below 10 kHz fails, 200 kHz passes
// - stop with monitor enabled resets (code: stop_i only halts the watchdog; monitor trips on e_clk_en_i gaps)
// - monitor enable read/write, reset clears
// - irq sense bit, level or edge
// - watchdog stops when clock stops
`ifndef RST_WDOG_DEFINES_SVH
`define RST_WDOG_DEFINES_SVH

`define ADDR_OPTIONS 4'h0
`define ADDR_SERVICE 4'h4
`define ADDR_TEST 4'h8
`define ADDR_STATUS 4'hC

`define OPT_RATE_LO 0
`define OPT_MON_EN 3
`define OPT_DLY 4
`define OPT_IRQ_EDGE_SELECT 5
`define OPT_CONVERTER_CLOCK_SEL 6
`define OPT_CONVERTER_POWER_UP 7
`define OPT_RESET 8'h10

`define SVC_ARM 8'h55
`define SVC_CLEAR 8'hAA

`define VEC_NORMAL 16'hFFFE
`define VEC_MONITOR 16'hFFFC
`define VEC_WATCHDOG 16'hFFFA
`define VEC_SPECIAL_MASK 16'hBFFF

`define POR_CYCLES 4064
`define PIN_DRIVE_CYCLES 4
`define PIN_SAMPLE_CYCLES 2
`define PIN_SYNC_CYCLES 4
`define RATE_WINDOW 64
`define WDOG_PRESCALE_BITS 15
`define CLK_PERIOD_NS 10
`define MON_TIMEOUT_NS 20000
`define MON_CYCLES (`MON_TIMEOUT_NS / `CLK_PERIOD_NS)

`endif

// ===== design/rst_wdog_pkg.sv
// types for the reset, watchdog and clock monitor block
package rst_wdog_pkg;
	typedef enum logic [1:0] {
		CAUSE_EXTERNAL,
		CAUSE_MONITOR,
		CAUSE_WATCHDOG
	} cause_t;

	typedef enum {
		ST_POR,
		ST_DRIVE,
		ST_SETTLE,
		ST_WAIT_PIN,
		ST_RUN
	} seq_state_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_t;
endpackage : rst_wdog_pkg

// ===== test/ext_reset_circuit.sv
// external reset circuit: pull-up and switch on the reset pin
`timescale 1ns/1ps
module ext_reset_circuit (
	input wire logic hold_i,
	input wire logic pin_drv_i,
	input wire logic pin_oe_n_i,
	output logic pin_o
);
	// ==========
	// pull-up with no rc delay, rises once nobody drives
	assign pin_o = !hold_i && (pin_oe_n_i || pin_drv_i);
endmodule : ext_reset_circuit

// ===== test/rwcm_checker.sv
// port assertions for the reset, watchdog and clock monitor block
`timescale 1ns/1ps
module rwcm_checker #(
	parameter int POR_CYCLES = 4064
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	input wire logic reset_pin_i,
	input wire logic reset_pin_o,
	input wire logic reset_pin_oe_o,
	input wire logic cpu_reset_o,
	input wire logic [15:0] reset_vector_o
);
	int cnt_r;
	// cycles since reset release, saturating
	always_ff @(posedge clk_i) begin
		if (rst_i)
			cnt_r <= 0;
		else if (cnt_r < POR_CYCLES)
			cnt_r <= cnt_r + 1;
	end
	// ==========
	// properties
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not answered");
	a_pin_low: assert property (reset_pin_o == 1'b0)
		else $error("reset pin driven high");
	a_por_vector: assert property ($fell(rst_i) |-> cpu_reset_o &&
		reset_vector_o == 16'hFFFE)
		else $error("bad power-on reset state");
	a_por_hold: assert property ($fell(cpu_reset_o) |-> cnt_r >= POR_CYCLES)
		else $error("power-on hold too short");
	a_pin_wait: assert property ($fell(cpu_reset_o) |-> $past(reset_pin_i, 2))
		else $error("left reset with pin low");
	a_drive_len: assert property ($fell(reset_pin_oe_o) |->
		!reset_pin_oe_o [*4])
		else $error("pin drive too short");
	a_settle_len: assert property ($rose(reset_pin_oe_o) |->
		cpu_reset_o [*2])
		else $error("reset ended before pin sample");
	c_internal: cover property ($rose(cpu_reset_o));
	c_run: cover property ($fell(cpu_reset_o));
	c_ack: cover property (ack_o);
endmodule : rwcm_checker

bind reset_watchdog_clock_monitor rwcm_checker #(
	.POR_CYCLES(POR_CYCLES)
) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.ack_o(ack_o), .reset_pin_i(reset_pin_i), .reset_pin_o(reset_pin_o),
	.reset_pin_oe_o(reset_pin_oe_o), .cpu_reset_o(cpu_reset_o),
	.reset_vector_o(reset_vector_o)
);

// ===== test/tb_top.sv
// self-checking bench for the reset, watchdog and clock monitor block
`timescale 1ns/1ps
module tb_top;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, e_en = 1, hold = 0;
	logic stop = 0, wd_dis = 0;
	logic [3:0] adr = 0;
	logic [31:0] wdat = 0;
	logic [31:0] dat_o;
	logic ack_o, pin, pin_o, pin_oe_n, cpu_reset_o, irq_o;
	logic [15:0] vec;
	logic [7:0] exp_q[$];
	logic [7:0] r;
	int mismatches = 0, n_tests = 0, n;
	time t0;
	always #5 clk_i = ~clk_i;
	ext_reset_circuit ext (.hold_i(hold), .pin_drv_i(pin_o),
		.pin_oe_n_i(pin_oe_n), .pin_o(pin));
	reset_watchdog_clock_monitor #(.POR_CYCLES(20), .MON_CYCLES(50)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
		.reset_pin_i(pin), .reset_pin_o(pin_o), .reset_pin_oe_o(pin_oe_n),
		.e_clk_en_i(e_en), .stop_i(stop), .special_mode_i(1'b0),
		.watchdog_disable_cfg_i(wd_dis), .cpu_reset_o(cpu_reset_o),
		.reset_vector_o(vec), .irq_edge_select_o(irq_o),
		.converter_power_up_o(), .converter_clock_sel_o(),
		.osc_start_delay_en_o());
	// ==========
	// tasks
	task chk(input string s, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			$display("MISMATCH %s exp %h got %h", s, e, g);
			mismatches++;
		end
	endtask : chk
	task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		cyc <= 0;
		stb <= 0;
		we <= 0;
		@(posedge clk_i);
	endtask : bus
	task rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 8'h00);
	endtask : rd
	task wait_cpu(input logic lvl);
		do @(posedge clk_i); while (cpu_reset_o !== lvl);
	endtask : wait_cpu
	task end_sim();
		$display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim
	// read data checked against the oldest note
	always @(posedge clk_i) begin
		if (ack_o === 1'b1 && we === 1'b0) begin
			chk("rdata", exp_q.pop_front(), dat_o[7:0]);
		end
	end
	initial begin
		#600000;
		mismatches++;
		end_sim();
	end
	// ==========
	// main sequence
	initial begin
		r = $urandom(32'hc81c703e);
		repeat (20) @(posedge clk_i);
		rst_i <= 0;
		hold <= 1;
		repeat (60) @(posedge clk_i);
		chk("por_hold", 16'h1, cpu_reset_o);
		hold <= 0;
		wait_cpu(1'b0);
		chk("vector", 16'hFFFE, vec);
		rd(4'h0, 8'h10);
		rd(4'h8, 8'h01);
		rd(4'hC, 8'h08);
		rd(4'h2, 8'h00);
		r = $urandom;
		bus(1'b1, 4'h0, r);
		rd(4'h0, r & 8'hFB);
		chk("irq_sel", r[5], irq_o);
		bus(1'b1, 4'h0, ~r | 8'h08);
		rd(4'h0, {~r[7:3] | 5'h01, 1'b0, r[1:0]});
		bus(1'b1, 4'h4, 8'h55);
		rd(4'hC, 8'h18);
		bus(1'b1, 4'h4, 8'hAA);
		rd(4'hC, 8'h08);
		bus(1'b1, 4'h4, 8'hAA);
		rd(4'hC, 8'h08);
		e_en <= 0;
		wait_cpu(1'b1);
		e_en <= 1;
		wait_cpu(1'b0);
		t0 = $time;
		chk("vector", 16'hFFFC, vec);
		rd(4'hC, 8'h09);
		rd(4'h0, 8'h10);
		wait_cpu(1'b1);
		n = int'(($time - t0) / 10);
		chk("wdog_span", 16'h1, n >= 32760 && n <= 32800);
		wait_cpu(1'b0);
		chk("vector", 16'hFFFA, vec);
		wd_dis <= 1;
		rd(4'hC, 8'h0A);
		hold <= 1;
		wait_cpu(1'b1);
		repeat (12) @(posedge clk_i);
		hold <= 0;
		wait_cpu(1'b0);
		chk("vector", 16'hFFFE, vec);
		rd(4'hC, 8'h00);
		end_sim();
	end
endmodule : tb_top
